// >>> design/host_mode_port.sv
// Host parallel port: mode low byte and indirect register access
`timescale 1ns/1ps
// Function
// - Soft reset bit resets device, self-clears
// - Selftest on: buffers allow reads and writes
// - Selftest off: tx write-only, rx read-only
// - Echo block bit stops automatic echo replies
// - Raw ICMP socket also suppresses echo reply
// - Automatic echo reply limited to 119 bytes
// - Bus swap exchanges bytes of all registers
// - Bus swap effective only on 16-bit bus
// - Addressing bit selects indirect or direct
// - Indirect mode maps only three registers
// - Address register holds offset, bit0 ignored
// - Data register reaches selected target bytes
// - Bus width latched from strap at reset
module host_mode_port
    import host_port_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_bus_width_strap,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [ADDR_W-1:0] i_host_addr,
    input wire logic [DATA_W-1:0] i_host_data,
    output logic [DATA_W-1:0] o_host_data,
    output logic o_host_data_oe,
    input wire logic [7:0] i_mode_high_byte,
    input wire logic i_fifo_byte_swap,
    output logic [ADDR_W-1:0] o_core_addr,
    output logic [DATA_W-1:0] o_core_wdata,
    output logic [1:0] o_core_be,
    output logic o_core_wr,
    output logic o_core_rd,
    input wire logic [DATA_W-1:0] i_core_rdata,
    input wire logic [SOCK_COUNT-1:0] i_socket_raw_ip_mode,
    input wire logic [SOCK_COUNT*8-1:0] i_socket_protocol_number,
    input wire logic [10:0] i_echo_req_len,
    output logic o_echo_reply_en,
    output logic o_soft_reset,
    output logic o_bus_width_flag,
    output logic o_pppoe_mode,
    output logic o_mem_selftest_bit
);
    logic [2:0] strb_s1_q, strb_s2_q, strb_q;
    logic [ADDR_W-1:0] addr_s1_q, addr_s2_q;
    logic [DATA_W-1:0] data_s1_q, data_s2_q;
    logic [7:0] mode_low_q;
    logic [15:0] indirect_address_q, indirect_data_q;
    logic [7:0] srst_cnt_q;
    logic width_taken_q, strap_s1_q, strap_s2_q;
    logic [1:0] width_wait_q;
    acc_state_e acc_q;
    logic rd_act, wr_act, rd_start, wr_end, srst, rd_go, wr_go;
    logic mode_hit, iaddr_hit, idata_hit, core_hit, indirect_mode;
    logic wide_bus, swap_all, swap_lane, tx_win, rx_win, buf_block;
    logic [ADDR_W-1:0] tgt_addr, win_off;
    logic [DATA_W-1:0] wdata, rdata_mux, rdata_raw;
    logic [1:0] be;
    logic [SOCK_COUNT-1:0] icmp_raw;

    // Pins come from the host's timing domain
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            strb_s1_q <= 3'h7;
            strb_s2_q <= 3'h7;
            strb_q <= 3'h7;
            addr_s1_q <= '0;
            addr_s2_q <= '0;
            data_s1_q <= '0;
            data_s2_q <= '0;
        end
        else if (i_ce)
        begin
            strb_s1_q <= {i_cs_n, i_rd_n, i_wr_n};
            strb_s2_q <= strb_s1_q;
            strb_q <= strb_s2_q;
            addr_s1_q <= i_host_addr;
            addr_s2_q <= addr_s1_q;
            data_s1_q <= i_host_data;
            data_s2_q <= data_s1_q;
        end
    end

    assign rd_act = !strb_s2_q[2] && !strb_s2_q[1];
    assign wr_act = !strb_s2_q[2] && !strb_s2_q[0];
    assign rd_start = rd_act && !(!strb_q[2] && !strb_q[1]);
    // Data is taken at the trailing edge so it has settled on the bus
    assign wr_end = !wr_act && !strb_q[2] && !strb_q[0];

    // Strap is a pin: synchronised, then taken once the pipe has filled
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
            width_wait_q <= 2'b00;
            width_taken_q <= 1'b0;
            o_bus_width_flag <= 1'b0;
        end
        else if (i_ce)
        begin
            strap_s1_q <= i_bus_width_strap;
            strap_s2_q <= strap_s1_q;
            width_wait_q <= {width_wait_q[0], 1'b1};
            if (width_wait_q[1] && !width_taken_q)
            begin
                width_taken_q <= 1'b1;
                o_bus_width_flag <= strap_s2_q;
            end
        end
    end

    assign wide_bus = o_bus_width_flag;
    assign indirect_mode = mode_low_q[MODE_INDIRECT_BIT];
    assign mode_hit = addr_s2_q[ADDR_W-1:1] == MODE_ADDR[ADDR_W-1:1];
    assign iaddr_hit = indirect_mode &&
        addr_s2_q[ADDR_W-1:1] == IADDR_ADDR[ADDR_W-1:1];
    assign idata_hit = indirect_mode &&
        addr_s2_q[ADDR_W-1:1] == IDATA_ADDR[ADDR_W-1:1];
    // Outside the three mapped words nothing is reached indirectly
    assign core_hit = indirect_mode ? idata_hit : !mode_hit;
    assign tgt_addr = indirect_mode ?
        {indirect_address_q[ADDR_W-1:1], 1'b0} :
        {addr_s2_q[ADDR_W-1:1], 1'b0};
    assign win_off = tgt_addr - SOCK_BASE;
    assign tx_win = tgt_addr >= SOCK_BASE &&
        (win_off & 10'h03f) == SOCK_TX_WIN;
    assign rx_win = tgt_addr >= SOCK_BASE &&
        (win_off & 10'h03f) == SOCK_RX_WIN;
    // Without selftest each buffer only moves in its own direction
    assign buf_block = !mode_low_q[MODE_SELFTEST_BIT] &&
        ((tx_win && rd_act) ||
         (rx_win && acc_q == ACC_WRITE));
    assign swap_all = mode_low_q[MODE_SWAP_BIT] && wide_bus;
    assign swap_lane = swap_all ^
        (i_fifo_byte_swap && (tx_win || rx_win) && core_hit);
    // 8-bit bus: even address is the high byte, odd the low byte
    assign be = wide_bus ? 2'b11 :
        (addr_s2_q[0] ? 2'b01 : 2'b10);
    assign wdata = !wide_bus ? {data_s2_q[7:0], data_s2_q[7:0]} :
        (swap_lane ? {data_s2_q[7:0], data_s2_q[15:8]} : data_s2_q);

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            acc_q <= ACC_IDLE;
        else if (i_ce)
        begin
            case (acc_q)
                ACC_IDLE: acc_q <= rd_start ? ACC_READ :
                    (wr_act ? ACC_WRITE : ACC_IDLE);
                ACC_READ: acc_q <= rd_act ? ACC_READ : ACC_IDLE;
                ACC_WRITE: acc_q <= wr_end ? ACC_IDLE : ACC_WRITE;
                default: acc_q <= ACC_IDLE;
            endcase
        end
    end

    assign rd_go = rd_start && core_hit && !buf_block && !srst;
    assign wr_go = acc_q == ACC_WRITE && wr_end && core_hit &&
        !buf_block && !srst;

    // One core strobe per host access so side effects happen once
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_core_rd <= 1'b0;
            o_core_wr <= 1'b0;
            o_core_addr <= '0;
            o_core_wdata <= '0;
            o_core_be <= 2'b00;
        end
        else if (i_ce)
        begin
            o_core_rd <= rd_go;
            o_core_wr <= wr_go;
            // Target lines stand from the strobe until the next access
            if (rd_go || wr_go)
            begin
                o_core_addr <= tgt_addr;
                o_core_be <= be;
            end
            if (wr_go)
                o_core_wdata <= wdata;
        end
    end

    assign srst = srst_cnt_q != 8'h00;

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            srst_cnt_q <= 8'h00;
        else if (i_ce)
        begin
            if (srst)
                srst_cnt_q <= srst_cnt_q - 8'h01;
            else if (acc_q == ACC_WRITE && wr_end && mode_hit && be[0] &&
                     wdata[MODE_SOFT_RESET_BIT])
                srst_cnt_q <= SOFT_RST_CNT;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            mode_low_q <= MODE_LOW_RESET;
            indirect_address_q <= IADDR_RESET;
            indirect_data_q <= IDATA_RESET;
        end
        else if (i_ce)
        begin
            if (srst)
            begin
                mode_low_q <= MODE_LOW_RESET;
                indirect_address_q <= IADDR_RESET;
                indirect_data_q <= IDATA_RESET;
            end
            else if (acc_q == ACC_WRITE && wr_end)
            begin
                if (mode_hit && be[0])
                    // Bit 7 stands until the soft reset clears it
                    mode_low_q <= wdata[7:0] & MODE_WRITABLE_MASK;
                if (iaddr_hit && be[1])
                    indirect_address_q[15:8] <= wdata[15:8];
                if (iaddr_hit && be[0])
                    indirect_address_q[7:0] <= wdata[7:0];
                if (idata_hit && be[1])
                    indirect_data_q[15:8] <= wdata[15:8];
                if (idata_hit && be[0])
                    indirect_data_q[7:0] <= wdata[7:0];
            end
            else if (o_core_rd && indirect_mode)
                indirect_data_q <= i_core_rdata;
        end
    end

    always_comb
    begin
        if (mode_hit)
            rdata_raw = {i_mode_high_byte, mode_low_q};
        else if (iaddr_hit)
            rdata_raw = indirect_address_q;
        else if (core_hit && !buf_block)
            rdata_raw = i_core_rdata;
        else
            rdata_raw = 16'h0000;
    end

    // Swap covers every register, as the write path already does
    assign rdata_mux = swap_lane ?
        {rdata_raw[7:0], rdata_raw[15:8]} : rdata_raw;

    // Read data is registered one cycle after the core strobe
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_host_data <= '0;
            o_host_data_oe <= 1'b0;
        end
        else if (i_ce)
        begin
            o_host_data_oe <= rd_act;
            if (acc_q == ACC_READ && rd_act)
                o_host_data <= !wide_bus ? (addr_s2_q[0] ?
                    {8'h00, rdata_mux[7:0]} :
                    {8'h00, rdata_mux[15:8]}) : rdata_mux;
        end
    end

    generate
        for (genvar s = 0; s < SOCK_COUNT; s++)
        begin : g_icmp
            assign icmp_raw[s] = i_socket_raw_ip_mode[s] &&
                i_socket_protocol_number[s*8 +: 8] == ICMP_PROTO;
        end
    endgenerate

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_echo_reply_en <= 1'b0;
        else if (i_ce)
            o_echo_reply_en <= !mode_low_q[MODE_ECHO_BLOCK_BIT] &&
                !(|icmp_raw) &&
                i_echo_req_len <= ECHO_MAX_LEN;
    end

    assign o_soft_reset = srst;
    assign o_pppoe_mode = mode_low_q[MODE_PPPOE_BIT];
    assign o_mem_selftest_bit = mode_low_q[MODE_SELFTEST_BIT];

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn || !i_ce);

    sequence s_srst_req;
        acc_q == ACC_WRITE && wr_end && mode_hit && be[0] &&
            wdata[MODE_SOFT_RESET_BIT] && !srst;
    endsequence
    sequence s_srst_done;
        srst [*5] ##1 !srst && mode_low_q == MODE_LOW_RESET;
    endsequence

    chk_srst_self_clear: assert property (s_srst_req |=> s_srst_done)
        else $error("soft reset did not self clear");
    chk_srst_regs_reset: assert property (srst |=>
        mode_low_q == MODE_LOW_RESET && indirect_address_q == 16'h0000)
        else $error("soft reset left port registers set");
    chk_tx_no_read: assert property (o_core_rd && tx_win &&
        !o_mem_selftest_bit |-> 1'b0 || $past(srst))
        else $error("tx window read without selftest");
    chk_rx_no_write: assert property (o_core_wr && rx_win &&
        !$past(mode_low_q[MODE_SELFTEST_BIT]) |-> 1'b0)
        else $error("rx window written without selftest");
    chk_echo_block: assert property (mode_low_q[MODE_ECHO_BLOCK_BIT]
        |=> !o_echo_reply_en)
        else $error("echo reply while blocked");
    chk_echo_icmp_raw: assert property ((|icmp_raw) |=> !o_echo_reply_en)
        else $error("echo reply with raw icmp socket");
    chk_echo_length: assert property (i_echo_req_len > ECHO_MAX_LEN
        |=> !o_echo_reply_en)
        else $error("echo reply for oversize request");
    chk_width_stable: assert property (width_taken_q
        |=> $stable(o_bus_width_flag))
        else $error("bus width flag changed");
    chk_narrow_no_swap: assert property (!wide_bus |-> !swap_all)
        else $error("byte swap active on narrow bus");
    chk_indirect_addr: assert property (o_core_wr && $past(indirect_mode)
        |-> o_core_addr == {$past(indirect_address_q[ADDR_W-1:1]), 1'b0})
        else $error("indirect target address wrong");
    chk_one_strobe: assert property (o_core_rd |=> !o_core_rd)
        else $error("double core read for one access");
    chk_idata_copy: assert property (o_core_wr && $past(indirect_mode) &&
        o_core_be == 2'b11 |-> indirect_data_q == o_core_wdata)
        else $error("indirect data copy differs from target write");
endmodule : host_mode_port

// >>> common/host_port_pkg.sv
// Constants for the host mode and indirect access port
package host_port_pkg;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 16;
    // Host-visible map; only the low ADDR_W bits reach the pins
    localparam logic [16:0] MODE_ADDR = 17'h08000;
    localparam logic [16:0] IADDR_ADDR = 17'h08002;
    localparam logic [16:0] IDATA_ADDR = 17'h08004;
    localparam logic [15:0] IADDR_RESET = 16'h0000;
    localparam logic [15:0] IDATA_RESET = 16'h0000;
    localparam logic [7:0] MODE_LOW_RESET = 8'h00;
    // Mode low byte bit positions
    localparam int unsigned MODE_SOFT_RESET_BIT = 7;
    localparam int unsigned MODE_SELFTEST_BIT = 5;
    localparam int unsigned MODE_ECHO_BLOCK_BIT = 4;
    localparam int unsigned MODE_PPPOE_BIT = 3;
    localparam int unsigned MODE_SWAP_BIT = 2;
    localparam int unsigned MODE_INDIRECT_BIT = 0;
    localparam logic [7:0] MODE_WRITABLE_MASK = 8'hbd;
    // Socket windows: base + stride * n + window offset
    localparam logic [9:0] SOCK_BASE = 10'h200;
    localparam logic [9:0] SOCK_TX_WIN = 10'h02e;
    localparam logic [9:0] SOCK_RX_WIN = 10'h030;
    localparam int unsigned SOCK_COUNT = 8;
    localparam int unsigned SOCK_SHIFT = 6;
    localparam logic [7:0] ICMP_PROTO = 8'h01;
    localparam logic [10:0] ECHO_MAX_LEN = 11'h077;
    // Soft reset hold time
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned SOFT_RST_NS = 100;
    localparam int unsigned SOFT_RST_CYCLES =
        (SOFT_RST_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] SOFT_RST_CNT = 8'(SOFT_RST_CYCLES);

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_READ = 2'b01,
        ACC_WRITE = 2'b10
    } acc_state_e;
endpackage : host_port_pkg

// >>> sim/host_cpu_model.sv
// Host processor model driving the parallel register pins
`timescale 1ns/1ps
module host_cpu_model
    import host_port_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic [DATA_W-1:0] i_rdata,
    output logic o_cs_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic [ADDR_W-1:0] o_addr,
    output logic [DATA_W-1:0] o_wdata
);
    initial
    begin
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_addr = '0;
        o_wdata = '0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_core_clk);
        #2;
    endtask : step
    // Strobes held 4 edges low and 5 high: above the 3-cycle minimum
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        o_addr = a;
        o_wdata = d;
        o_cs_n = 1'b0;
        o_wr_n = 1'b0;
        step(4);
        o_cs_n = 1'b1;
        o_wr_n = 1'b1;
        // Data is held one edge past the strobe, then the bus goes stale
        step(1);
        o_wdata = ~d;
        o_addr = ~a;
        step(4);
    endtask : wr
    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        o_addr = a;
        o_cs_n = 1'b0;
        o_rd_n = 1'b0;
        step(5);
        d = i_rdata;
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        step(1);
        o_addr = ~a;
        step(4);
    endtask : rd
endmodule : host_cpu_model

// >>> sim/tb.sv
// Self-checking bench for the host mode and indirect access port
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            n_fail++; \
            $display("BAD %s exp=%h got=%h", nm, e, g); \
        end \
    end
module tb
    import host_port_pkg::*;
;
    logic i_core_clk, i_rstn, strap, cs_n, rd_n, wr_n, c_wr, c_rd, flag;
    logic [9:0] addr, c_addr;
    logic [15:0] wdata, hdata, c_wdata, c_rdata, v;
    logic [1:0] c_be;
    logic [7:0] raw;
    logic [63:0] proto;
    logic [10:0] len;
    logic echo_en, srst, pppoe, mtest, ce, fswap, oe;
    int n_oe = 0;
    int n_fail = 0, total_checks = 0, n_wr = 0, n_rd = 0, n_srst = 0;
    host_mode_port i_dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
        .i_ce(ce), .i_bus_width_strap(strap), .i_cs_n(cs_n),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .i_host_addr(addr),
        .i_host_data(wdata), .o_host_data(hdata), .o_host_data_oe(oe),
        .i_mode_high_byte(8'ha5), .i_fifo_byte_swap(fswap),
        .o_core_addr(c_addr), .o_core_wdata(c_wdata), .o_core_be(c_be),
        .o_core_wr(c_wr), .o_core_rd(c_rd), .i_core_rdata(c_rdata),
        .i_socket_raw_ip_mode(raw), .i_socket_protocol_number(proto),
        .i_echo_req_len(len), .o_echo_reply_en(echo_en),
        .o_soft_reset(srst), .o_bus_width_flag(flag),
        .o_pppoe_mode(pppoe), .o_mem_selftest_bit(mtest));
    host_cpu_model i_host (.i_core_clk(i_core_clk), .i_rdata(hdata),
        .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(addr),
        .o_wdata(wdata));
    function automatic logic [15:0] tgt(input logic [9:0] a);
        return {a[7:0], a[9:2]} ^ 16'h3c00;
    endfunction : tgt
    // Target model answers combinationally in the read strobe cycle
    assign c_rdata = tgt(c_addr);
    initial
    begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk)
    begin
        n_wr += int'(c_wr === 1'b1);
        n_rd += int'(c_rd === 1'b1);
        n_srst += int'(srst === 1'b1);
        n_oe += int'(oe === 1'b1);
    end
    task automatic do_reset(input logic s);
        i_rstn = 1'b0;
        strap = s;
        repeat (12) @(posedge i_core_clk);
        #2;
        i_rstn = 1'b1;
        // Strap passes two sync stages before it is taken
        i_host.step(3);
        `CHK("width_flag", s, flag)
    endtask : do_reset
    task automatic t_mode();
        i_host.wr(10'h000, 16'h0079);
        `CHK("pppoe", 1'b1, pppoe)
        `CHK("selftest", 1'b1, mtest)
        `CHK("echo_blocked", 1'b0, echo_en)
        i_host.rd(10'h000, v);
        `CHK("mode_read", 16'ha539, v)
    endtask : t_mode
    task automatic echo(input int sock, input logic [7:0] p,
        input logic [10:0] l, input logic e);
        raw = 8'h01 << sock;
        proto = 64'(p) << (sock * 8);
        len = l;
        i_host.step(3);
        `CHK("echo_en", e, echo_en)
    endtask : echo
    task automatic t_echo();
        i_host.wr(10'h000, 16'h0001);
        echo(3, 8'h06, 11'd119, 1'b1);
        echo(3, 8'h06, 11'd120, 1'b0);
        echo(3, 8'h01, 11'd10, 1'b0);
        echo(7, 8'h11, 11'd10, 1'b1);
        // Frozen enable keeps the old answer until it is raised again
        ce = 1'b0;
        echo(3, 8'h01, 11'd10, 1'b1);
        ce = 1'b1;
        i_host.step(1);
        `CHK("echo_thaw", 1'b0, echo_en)
    endtask : t_echo
    task automatic t_ind();
        int w;
        int r;
        int o;
        i_host.wr(10'h002, 16'h0203);
        w = n_wr;
        i_host.wr(10'h004, 16'h80f0);
        `CHK("wr_count", w + 1, n_wr)
        `CHK("core_addr", 10'h202, c_addr)
        `CHK("core_wdata", 16'h80f0, c_wdata)
        `CHK("core_be", 2'b11, c_be)
        r = n_rd;
        o = n_oe;
        i_host.rd(10'h004, v);
        `CHK("ind_read", tgt(10'h202), v)
        // The model holds its read strobe over five edges
        `CHK("oe_cycles", o + 5, n_oe)
        `CHK("rd_count", r + 1, n_rd)
        i_host.rd(10'h010, v);
        `CHK("unmapped", 16'h0000, v)
    endtask : t_ind
    task automatic t_win();
        int w;
        int r;
        i_host.wr(10'h002, 16'h026e);
        r = n_rd;
        i_host.rd(10'h004, v);
        `CHK("tx_read_off", 16'h0000, v)
        `CHK("tx_rd_none", r, n_rd)
        i_host.wr(10'h002, 16'h0270);
        w = n_wr;
        i_host.wr(10'h004, 16'h1234);
        `CHK("rx_wr_none", w, n_wr)
        i_host.wr(10'h000, 16'h0021);
        i_host.wr(10'h004, 16'h1234);
        `CHK("rx_wr_test", w + 1, n_wr)
        i_host.wr(10'h002, 16'h026e);
        i_host.rd(10'h004, v);
        `CHK("tx_read_test", tgt(10'h26e), v)
        fswap = 1'b1;
        i_host.rd(10'h004, v);
        `CHK("fifo_swap", tgt(10'h26e), {v[7:0], v[15:8]})
        fswap = 1'b0;
    endtask : t_win
    task automatic t_swap_srst();
        i_host.wr(10'h000, 16'h0005);
        i_host.wr(10'h002, 16'h0202);
        i_host.rd(10'h004, v);
        `CHK("swapped", {v[7:0], v[15:8]}, tgt(10'h202))
        n_srst = 0;
        // Swap still active, so the reset bit travels in the upper lane
        i_host.wr(10'h000, 16'h8000);
        i_host.step(8);
        `CHK("srst_len", int'(SOFT_RST_CYCLES), n_srst)
        i_host.rd(10'h000, v);
        `CHK("mode_after", 16'ha500, v)
        i_host.wr(10'h000, 16'h0001);
        i_host.rd(10'h002, v);
        `CHK("iaddr_after", IADDR_RESET, v)
    endtask : t_swap_srst
    task automatic t_narrow();
        do_reset(1'b0);
        // Mode low byte sits at the odd address on a narrow bus
        i_host.wr(10'h001, 16'h0005);
        i_host.wr(10'h002, 16'h0002);
        i_host.wr(10'h003, 16'h0004);
        i_host.rd(10'h004, v);
        `CHK("lane_high", tgt(10'h204) >> 8, v)
        i_host.rd(10'h005, v);
        `CHK("lane_low", tgt(10'h204) & 16'h00ff, v)
    endtask : t_narrow
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    initial
    begin
        raw = 8'h00;
        proto = '0;
        len = 11'd0;
        ce = 1'b1;
        fswap = 1'b0;
        do_reset(1'b1);
        t_mode();
        t_echo();
        t_ind();
        t_win();
        t_swap_srst();
        t_narrow();
        complete_run();
    end
    // Whole sequence needs well under 1000 host cycles
    initial
    begin
        #400000;
        n_fail++;
        complete_run();
    end
endmodule : tb
